// ==== logic/mbw_pkg.sv ====
// Constants, addresses and types shared by the host watchdog and I/O map design
package mbw_pkg;

  // Function codes and the exception flag added to them
  localparam logic [7:0] FN_READ_COILS  = 8'h01;
  localparam logic [7:0] FN_READ_HOLD   = 8'h03;
  localparam logic [7:0] FN_READ_INPUT  = 8'h04;
  localparam logic [7:0] FN_WRITE_COIL  = 8'h05;
  localparam logic [7:0] FN_WRITE_REG   = 8'h06;
  localparam logic [7:0] FN_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FN_EXC_FLAG    = 8'h80;

  // Exception codes
  localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  // Channel addresses (zero-based protocol addresses)
  localparam logic [15:0] ADR_DO_BASE        = 16'h0000;
  localparam logic [15:0] ADR_DI_BASE        = 16'h0020;
  localparam logic [15:0] ADR_LATCH_HI_BASE  = 16'h0040;
  localparam logic [15:0] ADR_LATCH_LO_BASE  = 16'h0060;
  localparam logic [15:0] ADR_SAFE_BASE      = 16'h0080;
  localparam logic [15:0] ADR_WD_ENABLE      = 16'h0104;
  localparam logic [15:0] ADR_LATCH_CLEAR    = 16'h0107;
  localparam logic [15:0] ADR_WD_FLAG        = 16'h010D;
  localparam logic [15:0] ADR_WD_INTERVAL    = 16'h01E8;
  localparam logic [15:0] ADR_CNT_CLEAR_BASE = 16'h0200;
  localparam logic [15:0] ADR_CNT_BASE       = 16'h0000;
  localparam logic [15:0] ADR_KEEPALIVE      = 16'h3038;

  // Values and limits
  localparam logic [15:0] COIL_ON         = 16'hFF00;
  localparam logic [15:0] COIL_OFF        = 16'h0000;
  localparam logic [15:0] KEEPALIVE_VALUE = 16'h0000;
  localparam logic [15:0] INTERVAL_MAX    = 16'h00FF;
  localparam logic [15:0] MAX_BIT_QTY     = 16'h0010;
  localparam logic [15:0] MAX_REG_QTY     = 16'h0004;
  localparam logic [7:0]  STATION_MIN     = 8'h01;
  localparam logic [7:0]  STATION_MAX     = 8'hF7;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [15:0] NUM_DI_WIDE     = 16'h0010;
  localparam logic [15:0] NUM_DI_NARROW   = 16'h0008;
  localparam logic [15:0] NUM_DO          = 16'h0008;

  // Reset values
  localparam logic       WD_ENABLE_RST   = 1'b0;
  localparam logic [7:0] WD_INTERVAL_RST = 8'h00;
  localparam logic [7:0] COILS_RST       = 8'h00;
  localparam logic [7:0] SAFE_RST        = 8'h00;

  // Timing: one interval step is a tenth of a second
  localparam int unsigned TENTH_SECOND_NS     = 100000000;
  localparam int unsigned CLK_PERIOD_NS       = 5;
  localparam int unsigned TENTH_SECOND_CYCLES = TENTH_SECOND_NS / CLK_PERIOD_NS;

  // Kind of answer produced for a request
  typedef enum logic [1:0] {RSP_NONE, RSP_ECHO, RSP_READ, RSP_EXC} mbw_rsp_kind_t;

endpackage

// ==== logic/mbw_di_channel.sv ====
// One discrete input channel: synchroniser, high/low latches and edge counter
`timescale 1ns/1ps
module mbw_di_channel
  import mbw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Input pin, asynchronous to clk_sys
  input  wire logic        din_pin,
  // Clear strobes from the command decoder
  input  wire logic        latch_clear,
  input  wire logic        count_clear,
  // Channel state
  output logic             level,
  output logic             latch_high,
  output logic             latch_low,
  output logic [15:0]      count
);

  typedef struct packed {
    logic        meta;
    logic        sync;
    logic        prev;
    logic        hi;
    logic        lo;
    logic [15:0] cnt;
    logic [1:0]  fill;
  } mbw_di_state_t;

  mbw_di_state_t q;
  mbw_di_state_t d;
  logic          rising;

  // Next state; a level seen in the clear cycle keeps its latch set
  always_comb begin
    d       = q;
    rising  = q.sync & ~q.prev;
    d.meta  = din_pin;
    d.sync  = q.meta;
    d.prev  = q.sync;
    d.fill  = {q.fill[0], 1'b1};
    if (latch_clear) begin
      d.hi = 1'b0;
      d.lo = 1'b0;
    end
    // Latch only a sampled pin, never the reset zero
    if (q.fill[1]) begin
      if (q.sync) begin
        d.hi = 1'b1;
      end else begin
        d.lo = 1'b1;
      end
    end
    // Counter saturates rather than wrapping so a reader never sees a reset
    if (count_clear) begin
      d.cnt = {15'h0000, rising};
    end else if (rising && q.cnt != CNT_MAX) begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level      = q.sync;
  assign latch_high = q.hi;
  assign latch_low  = q.lo;
  assign count      = q.cnt;

endmodule  // mbw_di_channel

// ==== logic/mbw_host_watchdog.sv ====
// Host watchdog and request handler for the isolated digital I/O module
`timescale 1ns/1ps
// Behaviour
// - Coil read of the flag channel answers one byte, 0x00 clear or 0x01 timed out.
// - Holding read of the interval channel returns two bytes, 0x0000 to 0x00FF.
// - Single-register write sets interval 0..255 tenths; a larger value is refused as illegal value.
// - Single-coil write at watchdog_enable_coil enables on 0xFF00, disables on 0x0000.
// - Single-coil write of 0xFF00 at the flag channel clears the timeout flag unless a timeout expires in the same cycle.
// - Successful single writes echo address, function, channel and value unchanged.
// - A failing command replies function plus 0x80 and one exception code.
// - Sixteen-input variant shows live inputs as read-only bits 00033 to 00048.
// - Sixteen-input variant holds high latches 00065-00080 and low latches 00097-00112.
// - A write to reference 00264 clears all input latches on both variants except the latch of each channel's present level.
// - Sixteen-input variant gives read-only counters at input registers 30001-30016.
// - Writes at 00513 to 00528 reset the matching channel counter.
// - Eight-input variant maps inputs, latches, counters and clears over eight channels.
// - Eight-output variant exposes outputs as read/write coils 00001 to 00008.
// - Eight-output variant stores per-channel safe values via multi-coil writes at 0x0080.
module mbw_host_watchdog
  import mbw_pkg::*;
#(
  parameter bit          VARIANT_DIO = 1'b0,
  parameter int unsigned TICK_CYCLES = TENTH_SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Station configuration
  input  wire logic [7:0]  station_addr,
  // Parsed request from the serial front end
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_station,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_chan,
  input  wire logic [15:0] req_value,
  input  wire logic [15:0] req_coil_data,
  // Response to the serial front end
  output logic             rsp_valid,
  output logic [7:0]       rsp_station,
  output logic [7:0]       rsp_func,
  output logic [7:0]       rsp_exc_code,
  output logic [15:0]      rsp_chan,
  output logic [15:0]      rsp_value,
  output logic [7:0]       rsp_byte_count,
  output logic [63:0]      rsp_data,
  // Input pins and output channels
  input  wire logic [15:0] din_pins,
  output logic [7:0]       do_out,
  output logic [7:0]       safe_value,
  // Watchdog status
  output logic             host_watchdog_enabled,
  output logic             host_watchdog_flag
);

  localparam logic [15:0] NUM_DI   = VARIANT_DIO ? NUM_DI_NARROW : NUM_DI_WIDE;
  localparam logic [24:0] TICK_END = 25'(TICK_CYCLES - 1);

  typedef struct packed {
    logic        wd_en;
    logic        wd_flag;
    logic [7:0]  wd_interval;
    logic [24:0] tick_cnt;
    logic [7:0]  tenth_cnt;
    logic [7:0]  coils;
    logic [7:0]  safe;
    logic        rsp_valid;
    logic [7:0]  rsp_station;
    logic [7:0]  rsp_func;
    logic [7:0]  rsp_exc;
    logic [15:0] rsp_chan;
    logic [15:0] rsp_value;
    logic [7:0]  rsp_bytes;
    logic [63:0] rsp_data;
  } mbw_top_state_t;

  mbw_top_state_t q;
  mbw_top_state_t d;

  // Channel state gathered from the per-channel blocks
  logic [15:0]  di_level;
  logic [15:0]  di_hi;
  logic [15:0]  di_lo;
  logic [255:0] di_cnt;
  logic         latch_clr;
  logic [15:0]  cnt_clr;

  // True when the whole span start..start+qty-1 lies inside base..base+n-1
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] base,
                                    input logic [15:0] n, input logic [15:0] qty);
    logic [16:0] top_req;
    logic [16:0] top_reg;
    top_req  = {1'b0, a} + {1'b0, qty};
    top_reg  = {1'b0, base} + {1'b0, n};
    in_range = (a >= base) && (top_req <= top_reg);
  endfunction

  // Mask of the low qty bits, qty at most 16
  function automatic logic [15:0] low_mask(input logic [15:0] qty);
    logic [16:0] m;
    m        = (17'h00001 << qty[4:0]) - 17'h00001;
    low_mask = m[15:0];
  endfunction

  // Per-channel inputs; unused channels of the narrow variant read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_di
      if (gi < int'(NUM_DI)) begin : g_on
        mbw_di_channel u_chan (
          .clk_sys     (clk_sys),
          .rst         (rst),
          .din_pin     (din_pins[gi]),
          .latch_clear (latch_clr),
          .count_clear (cnt_clr[gi]),
          .level       (di_level[gi]),
          .latch_high  (di_hi[gi]),
          .latch_low   (di_lo[gi]),
          .count       (di_cnt[gi*16 +: 16])
        );
      end else begin : g_off
        assign di_level[gi]          = 1'b0;
        assign di_hi[gi]             = 1'b0;
        assign di_lo[gi]             = 1'b0;
        assign di_cnt[gi*16 +: 16]   = 16'h0000;
      end
    end
  endgenerate

  // Request decode, watchdog timer and response build
  always_comb begin
    mbw_rsp_kind_t kind;
    logic [7:0]    exc;
    logic          ours;
    logic          keepalive;
    logic          flag_clr;
    logic          expire;
    logic          coil_val_ok;
    logic [15:0]   src;
    logic [15:0]   base;
    logic [255:0]  shifted;
    logic [63:0]   words;
    logic [15:0]   rel;
    kind        = RSP_NONE;
    exc         = 8'h00;
    keepalive   = 1'b0;
    flag_clr    = 1'b0;
    expire      = 1'b0;
    src         = 16'h0000;
    base        = 16'h0000;
    shifted     = '0;
    words       = 64'h0000000000000000;
    rel         = 16'h0000;
    latch_clr   = 1'b0;
    cnt_clr     = 16'h0000;
    d           = q;
    d.rsp_valid = 1'b0;
    coil_val_ok = (req_value == COIL_ON) || (req_value == COIL_OFF);
    ours        = req_valid && (req_station == station_addr) &&
                  (station_addr >= STATION_MIN) && (station_addr <= STATION_MAX);

    if (ours) begin
      kind = RSP_EXC;
      exc  = EXC_ILLEGAL_ADDR;
      case (req_func)
        FN_READ_COILS: begin
          if (req_value == 16'h0000 || req_value > MAX_BIT_QTY) begin
            exc = EXC_ILLEGAL_VALUE;
          end else begin
            kind = RSP_READ;
            if (in_range(req_chan, ADR_WD_FLAG, 16'h0001, req_value)) begin
              src  = {15'h0000, q.wd_flag};
              base = ADR_WD_FLAG;
            end else if (in_range(req_chan, ADR_DI_BASE, NUM_DI, req_value)) begin
              src  = di_level;
              base = ADR_DI_BASE;
            end else if (in_range(req_chan, ADR_LATCH_HI_BASE, NUM_DI, req_value)) begin
              src  = di_hi;
              base = ADR_LATCH_HI_BASE;
            end else if (in_range(req_chan, ADR_LATCH_LO_BASE, NUM_DI, req_value)) begin
              src  = di_lo;
              base = ADR_LATCH_LO_BASE;
            end else if (VARIANT_DIO && in_range(req_chan, ADR_DO_BASE, NUM_DO, req_value)) begin
              src  = {8'h00, q.coils};
              base = ADR_DO_BASE;
            end else begin
              kind = RSP_EXC;
            end
            rel          = req_chan - base;
            d.rsp_data   = {48'h000000000000, (src >> rel[3:0]) & low_mask(req_value)};
            d.rsp_bytes  = (req_value > 16'h0008) ? 8'h02 : 8'h01;
          end
        end
        FN_READ_HOLD, FN_READ_INPUT: begin
          if (req_chan == ADR_KEEPALIVE && req_value == KEEPALIVE_VALUE) begin
            kind      = RSP_NONE;
            keepalive = 1'b1;
          end else if (req_value == 16'h0000 || req_value > MAX_REG_QTY) begin
            exc = EXC_ILLEGAL_VALUE;
          end else if (req_func == FN_READ_HOLD &&
                       in_range(req_chan, ADR_WD_INTERVAL, 16'h0001, req_value)) begin
            kind        = RSP_READ;
            d.rsp_data  = {56'h00000000000000, q.wd_interval};
            d.rsp_bytes = 8'h02;
          end else if (in_range(req_chan, ADR_CNT_BASE, NUM_DI, req_value)) begin
            kind        = RSP_READ;
            rel         = req_chan - ADR_CNT_BASE;
            shifted     = di_cnt >> {rel[3:0], 4'h0};
            for (int k = 0; k < 4; k++) begin
              words[k*16 +: 16] = (16'(k) < req_value) ? shifted[k*16 +: 16] : 16'h0000;
            end
            d.rsp_data  = words;
            d.rsp_bytes = {req_value[6:0], 1'b0};
          end
        end
        FN_WRITE_COIL: begin
          if (!coil_val_ok) begin
            exc = EXC_ILLEGAL_VALUE;
          end else if (req_chan == ADR_WD_ENABLE) begin
            kind    = RSP_ECHO;
            d.wd_en = (req_value == COIL_ON);
          end else if (req_chan == ADR_WD_FLAG) begin
            // Only the set value clears; a zero write is refused
            if (req_value == COIL_ON) begin
              kind     = RSP_ECHO;
              flag_clr = 1'b1;
            end else begin
              exc = EXC_ILLEGAL_VALUE;
            end
          end else if (req_chan == ADR_LATCH_CLEAR) begin
            kind      = RSP_ECHO;
            latch_clr = 1'b1;
          end else if (in_range(req_chan, ADR_CNT_CLEAR_BASE, NUM_DI, 16'h0001)) begin
            kind    = RSP_ECHO;
            rel     = req_chan - ADR_CNT_CLEAR_BASE;
            cnt_clr = 16'h0001 << rel[3:0];
          end else if (VARIANT_DIO && in_range(req_chan, ADR_DO_BASE, NUM_DO, 16'h0001)) begin
            kind                    = RSP_ECHO;
            d.coils[req_chan[2:0]]  = (req_value == COIL_ON);
          end
        end
        FN_WRITE_REG: begin
          if (req_chan != ADR_WD_INTERVAL) begin
            exc = EXC_ILLEGAL_ADDR;
          end else if (req_value > INTERVAL_MAX) begin
            exc = EXC_ILLEGAL_VALUE;
          end else begin
            kind          = RSP_ECHO;
            d.wd_interval = req_value[7:0];
          end
        end
        FN_WRITE_COILS: begin
          if (req_value == 16'h0000 || req_value > NUM_DI) begin
            exc = EXC_ILLEGAL_VALUE;
          end else if (in_range(req_chan, ADR_CNT_CLEAR_BASE, NUM_DI, req_value)) begin
            kind    = RSP_ECHO;
            rel     = req_chan - ADR_CNT_CLEAR_BASE;
            cnt_clr = (req_coil_data & low_mask(req_value)) << rel[3:0];
          end else if (VARIANT_DIO && in_range(req_chan, ADR_DO_BASE, NUM_DO, req_value)) begin
            kind = RSP_ECHO;
            for (int k = 0; k < 8; k++) begin
              if (16'(k) < req_value && k + int'(req_chan[2:0]) < 8) begin
                d.coils[k + int'(req_chan[2:0])] = req_coil_data[k];
              end
            end
          end else if (VARIANT_DIO && in_range(req_chan, ADR_SAFE_BASE, NUM_DO, req_value)) begin
            kind = RSP_ECHO;
            for (int k = 0; k < 8; k++) begin
              if (16'(k) < req_value && k + int'(req_chan[2:0]) < 8) begin
                d.safe[k + int'(req_chan[2:0])] = req_coil_data[k];
              end
            end
          end
        end
        default: begin
          exc = EXC_ILLEGAL_FUNC;
        end
      endcase
    end

    // Response latch; data and byte count only matter for reads
    case (kind)
      RSP_ECHO: begin
        d.rsp_valid = 1'b1;
        d.rsp_func  = req_func;
        d.rsp_exc   = 8'h00;
        d.rsp_chan  = req_chan;
        d.rsp_value = req_value;
        d.rsp_bytes = 8'h00;
        d.rsp_data  = 64'h0000000000000000;
      end
      RSP_READ: begin
        d.rsp_valid = 1'b1;
        d.rsp_func  = req_func;
        d.rsp_exc   = 8'h00;
        d.rsp_chan  = req_chan;
        d.rsp_value = req_value;
      end
      RSP_EXC: begin
        d.rsp_valid = 1'b1;
        d.rsp_func  = req_func | FN_EXC_FLAG;
        d.rsp_exc   = exc;
        d.rsp_chan  = req_chan;
        d.rsp_value = req_value;
        d.rsp_bytes = 8'h00;
        d.rsp_data  = 64'h0000000000000000;
      end
      RSP_NONE: begin
        d.rsp_valid = 1'b0;
      end
      default: begin
        d.rsp_valid = 1'b0;
      end
    endcase
    if (kind != RSP_NONE) begin
      d.rsp_station = req_station;
    end

    // Timer counts tenths only while enabled; an interval of zero never expires
    if (!q.wd_en || keepalive || q.wd_interval == 8'h00) begin
      d.tick_cnt  = 25'h0000000;
      d.tenth_cnt = 8'h00;
    end else if (q.tick_cnt == TICK_END) begin
      d.tick_cnt = 25'h0000000;
      if (q.tenth_cnt + 8'h01 == q.wd_interval) begin
        d.tenth_cnt = 8'h00;
        expire      = 1'b1;
      end else begin
        d.tenth_cnt = q.tenth_cnt + 8'h01;
      end
    end else begin
      d.tick_cnt = q.tick_cnt + 25'h0000001;
    end
    // A timeout in the clear cycle wins so no expiry is lost
    d.wd_flag = (q.wd_flag & ~flag_clr) | expire;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q             <= '0;
      q.wd_en       <= WD_ENABLE_RST;
      q.wd_interval <= WD_INTERVAL_RST;
      q.coils       <= COILS_RST;
      q.safe        <= SAFE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rsp_valid             = q.rsp_valid;
  assign rsp_station           = q.rsp_station;
  assign rsp_func              = q.rsp_func;
  assign rsp_exc_code          = q.rsp_exc;
  assign rsp_chan              = q.rsp_chan;
  assign rsp_value             = q.rsp_value;
  assign rsp_byte_count        = q.rsp_bytes;
  assign rsp_data              = q.rsp_data;
  assign do_out                = q.coils;
  assign safe_value            = q.safe;
  assign host_watchdog_enabled = q.wd_en;
  assign host_watchdog_flag    = q.wd_flag;

endmodule  // mbw_host_watchdog

// ==== test/mbw_host_watchdog_props.sv ====
// Port-level checks for the host watchdog block
`timescale 1ns/1ps
module mbw_props
  import mbw_pkg::*;
(
  // Clock, reset, station
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  station_addr,
  // Requests
  input wire logic        req_valid,
  input wire logic [7:0]  req_station,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_chan,
  input wire logic [15:0] req_value,
  // Answers and status
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_func,
  input wire logic [7:0]  rsp_exc_code,
  input wire logic [15:0] rsp_chan,
  input wire logic [15:0] rsp_value,
  input wire logic [7:0]  rsp_byte_count,
  input wire logic [63:0] rsp_data,
  input wire logic        host_watchdog_enabled,
  input wire logic        host_watchdog_flag
);
  // Request taken, and the two watchdog coil writes within it
  logic tk, en_w, fl_w;
  assign tk   = req_valid && req_station == station_addr && station_addr != 8'h00
                && station_addr <= STATION_MAX;
  assign en_w = tk && req_func == FN_WRITE_COIL && req_chan == ADR_WD_ENABLE;
  assign fl_w = tk && req_func == FN_WRITE_COIL && req_chan == ADR_WD_FLAG;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_enable_on: assert property (en_w && req_value == COIL_ON |=> host_watchdog_enabled)
    else $error("enable not set");
  a_enable_off: assert property (en_w && req_value == COIL_OFF |=> !host_watchdog_enabled)
    else $error("enable not cleared");
  a_write_echo: assert property (en_w && req_value == COIL_ON |=> rsp_valid
    && rsp_chan == $past(req_chan) && rsp_value == $past(req_value)) else $error("bad echo");
  // Clearing is the only way out of a timeout
  a_flag_sticky: assert property (host_watchdog_flag && !fl_w |=> host_watchdog_flag)
    else $error("flag dropped");
  a_flag_read: assert property (tk && req_func == FN_READ_COILS && req_chan == ADR_WD_FLAG
    && req_value == 16'h0001 |=> rsp_valid && rsp_byte_count == 8'h01
    && rsp_data[7:0] == {7'h00, $past(host_watchdog_flag)}) else $error("flag read");
  a_keepalive_quiet: assert property (tk && req_chan == ADR_KEEPALIVE && req_value == 16'h0000
    && (req_func == FN_READ_HOLD || req_func == FN_READ_INPUT) |=> !rsp_valid)
    else $error("keep-alive answered");
  a_interval_refused: assert property (tk && req_func == FN_WRITE_REG
    && req_chan == ADR_WD_INTERVAL && req_value > INTERVAL_MAX
    |=> rsp_func == 8'h86 && rsp_exc_code == EXC_ILLEGAL_VALUE) else $error("interval taken");
  a_exc_flagged: assert property (rsp_valid && rsp_func[7] |-> rsp_exc_code != 8'h00)
    else $error("exception without code");
  a_answer_cause: assert property (rsp_valid |-> $past(tk))
    else $error("answer without request");
endmodule // mbw_props

bind mbw_host_watchdog mbw_props u_props (.clk_sys, .rst, .station_addr, .req_valid,
  .req_station, .req_func, .req_chan, .req_value, .rsp_valid, .rsp_func, .rsp_exc_code,
  .rsp_chan, .rsp_value, .rsp_byte_count, .rsp_data, .host_watchdog_enabled,
  .host_watchdog_flag);

// ==== test/mbw_master.sv ====
// Behavioural bus master handing parsed requests to the device
`timescale 1ns/1ps
module mbw_master
  import mbw_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Request fields
  output logic             req_valid,
  output logic [7:0]       req_station,
  output logic [7:0]       req_func,
  output logic [15:0]      req_chan,
  output logic [15:0]      req_value
);
  // Quiet at time zero
  initial begin
    req_valid   = 1'b0;
    req_station = 8'h00;
    req_func    = 8'h00;
    req_chan    = 16'h0000;
    req_value   = 16'h0000;
  end

  // One request pulse; fields inverted after it so stale values never pass
  task automatic send(input logic [7:0] st, input logic [7:0] fn,
                      input logic [15:0] ch, input logic [15:0] val);
    @(posedge clk_sys);
    req_valid   <= 1'b1;
    req_station <= st;
    req_func    <= fn;
    req_chan    <= ch;
    req_value   <= val;
    @(posedge clk_sys);
    req_valid   <= 1'b0;
    req_station <= ~st;
    req_func    <= ~fn;
    req_chan    <= ~ch;
    req_value   <= ~val;
  endtask

  // Keep-alive: zero at its fixed channel
  task automatic keepalive(input logic [7:0] st, input logic [7:0] fn);
    send(st, fn, ADR_KEEPALIVE, KEEPALIVE_VALUE);
  endtask
endmodule // mbw_master

// ==== test/mbw_host_watchdog_tb_top.sv ====
// Self-checking bench for the host watchdog block, sixteen-input variant
`timescale 1ns/1ps
module mbw_host_watchdog_tb_top;
  import mbw_pkg::*;
  // Short tick keeps expiry within a few dozen cycles
  localparam int unsigned TICK = 10;
  localparam logic [7:0]  ST   = 8'h11;
  logic        clk_sys, rst, req_valid, rsp_valid, host_watchdog_enabled, host_watchdog_flag;
  logic [7:0]  req_station, req_func, rsp_station, rsp_func, rsp_exc_code, rsp_byte_count;
  logic [15:0] req_chan, req_value, rsp_chan, rsp_value, din_pins, hi, cd;
  logic [63:0] rsp_data;
  logic [31:0] s;
  int          errors, cmp_count, i, n;

  mbw_host_watchdog #(.VARIANT_DIO(1'b0), .TICK_CYCLES(TICK)) dut (
    .clk_sys, .rst, .station_addr(ST), .req_valid, .req_station, .req_func,
    .req_chan, .req_value, .req_coil_data(cd), .rsp_valid, .rsp_station,
    .rsp_func, .rsp_exc_code, .rsp_chan, .rsp_value, .rsp_byte_count, .rsp_data,
    .din_pins, .do_out(), .safe_value(), .host_watchdog_enabled, .host_watchdog_flag);
  mbw_master m (.clk_sys, .req_valid, .req_station, .req_func, .req_chan, .req_value);

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Cycles from restart to expiry
  function automatic int wd_expect(input int tenths);
    return tenths * TICK;
  endfunction

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One request; answer expected only for our station, function has 0x80 on refusal
  task automatic go(input logic [7:0] st, input logic [7:0] fn, input logic [15:0] ch,
                    input logic [15:0] val, input logic [7:0] ex);
    m.send(st, fn, ch, val);
    #1;
    chk(rsp_valid === (st === ST), "answer presence");
    if (st === ST) begin
      chk(rsp_exc_code === ex && rsp_station === st, "exception code");
      chk(rsp_func === (ex === 8'h00 ? fn : fn | 8'h80), "function code");
      if (ex === 8'h00 && (fn === FN_WRITE_COIL || fn === FN_WRITE_REG))
        chk(rsp_chan === ch && rsp_value === val, "echo");
    end
  endtask

  initial begin
    errors    = 0;
    cmp_count = 0;
    rst       = 1'b1;
    din_pins  = 16'h0000;
    s         = 32'h00013CA9;
    hi        = 16'h0000;
    cd        = 16'h0003;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(host_watchdog_flag === 1'b0 && host_watchdog_enabled === 1'b0, "reset");
    // Interval write, oversize refusal, read back
    go(ST, FN_WRITE_REG, ADR_WD_INTERVAL, 16'h0003, 8'h00);
    go(ST, FN_WRITE_REG, ADR_WD_INTERVAL, 16'h0100, EXC_ILLEGAL_VALUE);
    go(ST, FN_READ_HOLD, ADR_WD_INTERVAL, 16'h0001, 8'h00);
    chk(rsp_byte_count === 8'h02 && rsp_data[15:0] === 16'h0003, "interval");
    // Bad coil value, unknown function, strangers ignored
    go(ST, FN_WRITE_COIL, ADR_WD_ENABLE, 16'h1234, EXC_ILLEGAL_VALUE);
    go(ST, 8'h07, ADR_WD_ENABLE, COIL_ON, EXC_ILLEGAL_FUNC);
    go(ST + 8'h01, FN_WRITE_COIL, ADR_WD_ENABLE, COIL_ON, 8'h00);
    go(8'h00, FN_WRITE_COIL, ADR_WD_ENABLE, COIL_ON, 8'h00);
    chk(host_watchdog_enabled === 1'b0, "stranger obeyed");
    // Enable, keep alive at half the interval, then let it expire
    go(ST, FN_WRITE_COIL, ADR_WD_ENABLE, COIL_ON, 8'h00);
    chk(host_watchdog_enabled === 1'b1, "enable");
    for (i = 0; i < 4; i++) begin
      repeat (wd_expect(3) / 2) @(posedge clk_sys);
      m.keepalive(ST, i[0] ? FN_READ_INPUT : FN_READ_HOLD);
      #1;
      chk(rsp_valid === 1'b0 && host_watchdog_flag === 1'b0, "keep-alive");
    end
    n = 0;
    while (host_watchdog_flag !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n >= wd_expect(3) - 2 && n <= wd_expect(3) + 2, "expiry time");
    // Flag holds, reads back, clears only on request
    go(ST, FN_READ_COILS, ADR_WD_FLAG, 16'h0001, 8'h00);
    chk(rsp_byte_count === 8'h01 && rsp_data[7:0] === 8'h01, "flag set");
    go(ST, FN_WRITE_COIL, ADR_WD_ENABLE, COIL_OFF, 8'h00);
    chk(host_watchdog_enabled === 1'b0 && host_watchdog_flag === 1'b1, "disable");
    go(ST, FN_WRITE_COIL, ADR_WD_FLAG, COIL_ON, 8'h00);
    go(ST, FN_READ_COILS, ADR_WD_FLAG, 16'h0001, 8'h00);
    chk(rsp_data[7:0] === 8'h00 && host_watchdog_flag === 1'b0, "flag clear");
    // Random input patterns, corner pattern first
    for (i = 0; i < 6; i++) begin
      s = lfsr(s);
      @(posedge clk_sys);
      din_pins <= (i == 0) ? 16'h8001 : s[15:0];
      repeat (4) @(posedge clk_sys);
      hi |= din_pins;
      go(ST, FN_READ_COILS, ADR_DI_BASE, NUM_DI_WIDE, 8'h00);
      chk(rsp_data[15:0] === din_pins && rsp_byte_count === 8'h02, "inputs");
    end
    go(ST, FN_READ_COILS, ADR_LATCH_HI_BASE, NUM_DI_WIDE, 8'h00);
    chk(rsp_data[15:0] === hi, "high latch");
    go(ST, FN_WRITE_COIL, ADR_LATCH_CLEAR, COIL_ON, 8'h00);
    go(ST, FN_READ_COILS, ADR_LATCH_LO_BASE, NUM_DI_WIDE, 8'h00);
    chk(rsp_data[15:0] === ~din_pins, "low latch");
    // Counter clear on channel 0 with its pin steady
    go(ST, FN_WRITE_COIL, ADR_CNT_CLEAR_BASE, COIL_ON, 8'h00);
    go(ST, FN_READ_INPUT, ADR_CNT_BASE, 16'h0001, 8'h00);
    chk(rsp_data[15:0] === 16'h0000, "counter clear");
    // Multi-coil clear after new edges on channels 1 and 2
    @(posedge clk_sys);
    din_pins <= 16'h0000;
    repeat (3) @(posedge clk_sys);
    din_pins <= 16'h0006;
    repeat (4) @(posedge clk_sys);
    go(ST, FN_WRITE_COILS, ADR_CNT_CLEAR_BASE + 16'h0001, 16'h0002, 8'h00);
    go(ST, FN_READ_INPUT, ADR_CNT_BASE + 16'h0001, 16'h0002, 8'h00);
    chk(rsp_data[31:0] === 32'h00000000, "multi clear");
    conclude();
  end
endmodule // mbw_host_watchdog_tb_top
